// ---- pkg/cgr_pkg.sv ----
// cgr_pkg: constants and types for the clock generator control register bank.
// assumes an 8-bit register space reached over a two-wire serial bus.
package cgr_pkg;

  // serial bus addresses, write and read
  localparam logic [7:0] SMB_ADDR_WR = 8'hD2;
  localparam logic [7:0] SMB_ADDR_RD = 8'hD3;

  // register indices
  localparam logic [7:0] REG_PLL_DIV_EN  = 8'h00;
  localparam logic [7:0] REG_SPREAD_CTL  = 8'h01;
  localparam logic [7:0] REG_OUT_BUF_EN  = 8'h02;
  localparam logic [7:0] REG_OUT_MISC    = 8'h03;
  localparam logic [7:0] REG_SPREAD_HIGH = 8'h14;
  localparam logic [7:0] REG_CPU_DIV_EXT = 8'h15;
  localparam logic [7:0] REG_PNL_DIV_EXT = 8'h16;

  // reset values
  localparam logic [7:0] R0_RST  = 8'hEF;
  localparam logic [7:0] R1_RST  = 8'hC0;
  localparam logic [7:0] R2_RST  = 8'hFF;
  localparam logic [7:0] R3_RST  = 8'h30;
  localparam logic [7:0] R20_RST = 8'h00;
  localparam logic [7:0] R21_RST = 8'h00;
  localparam logic [7:0] R22_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h07;

  // writable bits; the rest are reserved and read zero
  localparam logic [7:0] R0_MASK  = 8'hEF;
  localparam logic [7:0] R1_MASK  = 8'hF8;
  localparam logic [7:0] R2_MASK  = 8'hFF;
  localparam logic [7:0] R3_MASK  = 8'h3F;
  localparam logic [7:0] R20_MASK = 8'hFF;
  localparam logic [7:0] R21_MASK = 8'hC0;
  localparam logic [7:0] R22_MASK = 8'hC0;

  // field positions
  localparam int B0_HOST_PLL   = 7;
  localparam int B0_PIXEL_PLL  = 6;
  localparam int B0_PANEL_PLL  = 5;
  localparam int B0_CPU_DIV    = 3;
  localparam int B0_PERIPH_DIV = 2;
  localparam int B0_PANEL_DIV  = 1;
  localparam int B0_PIXEL_DIV  = 0;
  localparam int B1_HOST_SS    = 7;
  localparam int B1_PANEL_SS   = 6;
  localparam int B1_SEL_LSB    = 3;
  localparam int B2_PIXEL_BUF  = 1;
  localparam int B2_PANEL_BUF  = 0;
  localparam int B3_REF_EN     = 5;
  localparam int B3_EDGE_LSB   = 3;
  localparam int B3_CPU0_STOP  = 2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK  = 3'b010,
    ST_SEND = 3'b011,
    ST_HACK = 3'b100
  } cgr_state_t;

  typedef enum logic [1:0] {
    PH_ADDR  = 2'b00,
    PH_INDEX = 2'b01,
    PH_COUNT = 2'b10,
    PH_DATA  = 2'b11
  } cgr_phase_t;

  // panel spread select codes: down spreads then centre spreads
  typedef enum logic [2:0] {
    SPR_DOWN_0P5    = 3'b000,
    SPR_DOWN_1P0    = 3'b001,
    SPR_DOWN_2P0    = 3'b010,
    SPR_DOWN_2P5    = 3'b011,
    SPR_CENTRE_0P25 = 3'b100,
    SPR_CENTRE_0P5  = 3'b101,
    SPR_CENTRE_1P0  = 3'b110,
    SPR_CENTRE_1P25 = 3'b111
  } cgr_spread_t;

  typedef enum logic [1:0] {
    EDGE_SLOW   = 2'b00,
    EDGE_MEDIUM = 2'b01,
    EDGE_FAST   = 2'b10,
    EDGE_RSVD   = 2'b11
  } cgr_edge_t;

endpackage : cgr_pkg

// ---- design/cgr_sync.sv ----
// cgr_sync: two-flop synchroniser for a group of asynchronous pins, with a
// third stage so the caller can detect edges without touching the first flop.
// assumes every bit is a slow level or a bus line far slower than i_clk.
`timescale 1ns/1ps
module cgr_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_prev
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] stab_reg;
  logic [W-1:0] prev_reg;

  // first stage feeds only the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_reg <= '0;
      stab_reg <= '0;
      prev_reg <= '0;
    end else begin
      meta_reg <= i_async;
      stab_reg <= meta_reg;
      prev_reg <= stab_reg;
    end
  end

  assign o_level = stab_reg;
  assign o_prev  = prev_reg;

endmodule : cgr_sync

// ---- design/cgr_regs.sv ----
// cgr_regs: control register bank of a multi-output clock generator,
// written and read over a two-wire serial bus with block transfers.
// assumes bus pins, power-good, halt and test straps are asynchronous.
// Contract
// RL1: byte0 bit7 enables host pll
// RL2: byte0 bit6 enables pixel pll
// RL3: byte0 bit5 enables panel pll
// RL4: cpu divider cleared when host pll off
// RL5: peripheral divider cleared when host pll off
// RL6: panel divider cleared when panel pll off
// RL7: pixel divider cleared when pixel pll off
// RL8: byte1 bit7 enables host fixed spread
// RL9: byte1 bit6 enables panel spread
// RL10: panel spread select applies only when enabled
// RL11: select codes map down then centre spreads
// RL12: byte2 enables cpu and peripheral buffers
// RL13: byte2 enables pixel and panel buffers
// RL14: byte3 enables reference buffer, reserved zero
// RL15: byte3 picks reference edge rate
// RL16: stoppable cpu outputs halt on halt input
// RL17: byte20 holds high spread word bits
// RL18: byte21 holds cpu feedback divider top
// RL19: byte22 holds panel feedback divider top
// RL20: test mode latched at power up only
// RL21: test output select chooses hiz or ref
// RL22: block write and read at fixed addresses
// RL23: reserved bits ignore writes, read zero
// RL24: power down resets, enables apply when idle
`timescale 1ns/1ps
module cgr_regs
  import cgr_pkg::*;
(
  input  wire logic       I_CLK,
  input  wire logic       I_SYS_RST,
  input  wire logic       I_SMB_SCL,
  input  wire logic       I_SMB_SDA,
  input  wire logic       I_POWER_GOOD_POWERDOWN,
  input  wire logic       I_CPU_CLOCK_HALT_N,
  input  wire logic       I_TEST_SEL,
  input  wire logic       I_TEST_OUTPUT_SEL,
  output logic            O_SMB_SDA_OUT,
  output logic            O_SMB_SDA_OE,
  output logic            O_HOST_PLL_EN,
  output logic            O_PIXEL_PLL_EN,
  output logic            O_PANEL_PLL_EN,
  output logic            O_CPU_DIV_EN,
  output logic            O_PERIPH_DIV_EN,
  output logic            O_PANEL_DIV_EN,
  output logic            O_PIXEL_DIV_EN,
  output logic            O_HOST_SPREAD_EN,
  output logic            O_PANEL_SPREAD_EN,
  output logic [2:0]      O_PANEL_SPREAD_SELECT,
  output logic            O_PANEL_SPREAD_CENTRE,
  output logic [2:0]      O_CPU_OUT_EN,
  output logic [2:0]      O_PERIPH_OUT_EN,
  output logic            O_PIXEL_OUT_EN,
  output logic            O_PANEL_OUT_EN,
  output logic            O_REF_OUT_EN,
  output logic [1:0]      O_REF_EDGE_RATE,
  output logic [7:0]      O_PANEL_SPREAD_WORD_HIGH,
  output logic [1:0]      O_CPU_FEEDBACK_DIV_HIGH,
  output logic [1:0]      O_PANEL_FEEDBACK_DIV_HIGH,
  output logic            O_TEST_MODE,
  output logic            O_TEST_HIZ,
  output logic            O_TEST_REF_DIV
);

  logic [5:0]  sync_lvl;
  logic [5:0]  sync_prv;
  cgr_state_t  state_reg,  state_next;
  cgr_phase_t  phase_reg,  phase_next;
  logic [3:0]  bit_cnt_reg, bit_cnt_next;
  logic        rw_reg,     rw_next;
  logic [7:0]  shift_reg,  shift_next;
  logic [7:0]  tx_reg,     tx_next;
  logic [7:0]  idx_reg,    idx_next;
  logic [7:0]  cnt_reg,    cnt_next;
  logic        sda_oe_reg, sda_oe_next;
  logic [7:0]  r0_reg, r1_reg, r2_reg, r3_reg;
  logic [7:0]  r20_reg, r21_reg, r22_reg;
  logic [7:0]  a0_reg, a1_reg, a2_reg, a3_reg;
  logic [1:0]  strap_cnt_reg;
  logic        test_mode_reg;

  // all bus, power-good, halt and test pins pass two flops before use
  cgr_sync #(.W(6)) u_sync (
    .i_clk   (I_CLK),
    .i_rst   (I_SYS_RST),
    .i_async ({I_TEST_OUTPUT_SEL, I_TEST_SEL, I_CPU_CLOCK_HALT_N,
               I_POWER_GOOD_POWERDOWN, I_SMB_SDA, I_SMB_SCL}),
    .o_level (sync_lvl),
    .o_prev  (sync_prv)
  );

  // bus line conditions from synchronised samples
  wire scl_s      = sync_lvl[0];
  wire sda_s      = sync_lvl[1];
  wire pd_s       = sync_lvl[2];
  wire halt_on    = ~sync_lvl[3];
  wire tsel_s     = sync_lvl[4];
  wire tout_s     = sync_lvl[5];
  wire scl_rise   = scl_s & ~sync_prv[0];
  wire scl_fall   = ~scl_s & sync_prv[0];
  wire start_det  = scl_s & sync_prv[0] & sync_prv[1] & ~sda_s;
  wire stop_det   = scl_s & sync_prv[0] & ~sync_prv[1] & sda_s;
  wire byte_full  = (bit_cnt_reg == 4'h8);
  wire addr_hit   = (shift_reg == SMB_ADDR_WR) || (shift_reg == SMB_ADDR_RD);
  wire byte_done  = (state_reg == ST_RECV) && scl_fall && byte_full;
  wire wr_en      = byte_done && (phase_reg == PH_DATA) && !pd_s && !stop_det
                    && !start_det;

  // register read selection; unmapped indices read zero
  wire [7:0] rd_byte = (idx_reg == REG_PLL_DIV_EN)  ? r0_reg  :
                       (idx_reg == REG_SPREAD_CTL)  ? r1_reg  :
                       (idx_reg == REG_OUT_BUF_EN)  ? r2_reg  :
                       (idx_reg == REG_OUT_MISC)    ? r3_reg  :
                       (idx_reg == REG_SPREAD_HIGH) ? r20_reg :
                       (idx_reg == REG_CPU_DIV_EXT) ? r21_reg :
                       (idx_reg == REG_PNL_DIV_EXT) ? r22_reg : 8'h00;

  // pll byte cleanup, shared by the write path
  function automatic logic [7:0] cgr_fix_pll(input logic [7:0] v);
    logic [7:0] f;
    f = v & R0_MASK;
    // RL5: host pll clears dividers
    if (!f[B0_HOST_PLL]) begin
      f[B0_CPU_DIV]    = 1'b0;
      f[B0_PERIPH_DIV] = 1'b0;
    end
    // RL6: panel pll clears divider
    if (!f[B0_PANEL_PLL]) begin
      f[B0_PANEL_DIV] = 1'b0;
    end
    // RL7: pixel pll clears divider
    if (!f[B0_PIXEL_PLL]) begin
      f[B0_PIXEL_DIV] = 1'b0;
    end
    return f;
  endfunction : cgr_fix_pll

  // byte level protocol engine
  // RL22: address, index, count, data sequence
  always_comb begin
    state_next   = state_reg;
    phase_next   = phase_reg;
    bit_cnt_next = bit_cnt_reg;
    rw_next      = rw_reg;
    shift_next   = shift_reg;
    tx_next      = tx_reg;
    idx_next     = idx_reg;
    cnt_next     = cnt_reg;
    sda_oe_next  = sda_oe_reg;
    if (pd_s || stop_det) begin
      state_next  = ST_IDLE;
      sda_oe_next = 1'b0;
    end else if (start_det) begin
      state_next   = ST_RECV;
      phase_next   = PH_ADDR;
      bit_cnt_next = 4'h0;
      sda_oe_next  = 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_RECV: begin
          if (scl_rise && !byte_full) begin
            shift_next   = {shift_reg[6:0], sda_s};
            bit_cnt_next = bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            // foreign address: stay off the bus until the next start
            if (phase_reg == PH_ADDR && !addr_hit) begin
              state_next = ST_IDLE;
            end else begin
              state_next  = ST_ACK;
              sda_oe_next = 1'b1;
            end
            if (phase_reg == PH_ADDR) rw_next = shift_reg[0];
            if (phase_reg == PH_INDEX) idx_next = shift_reg;
            if (phase_reg == PH_COUNT) cnt_next = shift_reg;
            if (phase_reg == PH_DATA) idx_next = idx_reg + 8'h01;
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            bit_cnt_next = 4'h0;
            if (rw_reg && phase_reg == PH_ADDR) begin
              // read opens with the byte count
              state_next  = ST_SEND;
              tx_next     = cnt_reg;
              sda_oe_next = ~cnt_reg[7];
            end else begin
              state_next  = ST_RECV;
              sda_oe_next = 1'b0;
              phase_next  = (phase_reg == PH_ADDR)  ? PH_INDEX :
                            (phase_reg == PH_INDEX) ? PH_COUNT : PH_DATA;
            end
          end
        end
        ST_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'h7) begin
              state_next  = ST_HACK;
              sda_oe_next = 1'b0;
            end else begin
              tx_next      = {tx_reg[6:0], 1'b0};
              sda_oe_next  = ~tx_reg[6];
              bit_cnt_next = bit_cnt_reg + 4'h1;
            end
          end
        end
        ST_HACK: begin
          if (scl_rise && sda_s) begin
            state_next = ST_IDLE; // host not-acknowledge ends the read
          end else if (scl_fall) begin
            state_next   = ST_SEND;
            bit_cnt_next = 4'h0;
            tx_next      = rd_byte;
            sda_oe_next  = ~rd_byte[7];
            idx_next     = idx_reg + 8'h01;
          end
        end
        default: begin
          state_next = ST_IDLE;
        end
      endcase
    end
  end

  // protocol state flops
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state_reg   <= ST_IDLE;
      phase_reg   <= PH_ADDR;
      bit_cnt_reg <= 4'h0;
      rw_reg      <= 1'b0;
      shift_reg   <= 8'h00;
      tx_reg      <= 8'h00;
      idx_reg     <= 8'h00;
      cnt_reg     <= CNT_RST;
      sda_oe_reg  <= 1'b0;
    end else begin
      state_reg   <= state_next;
      phase_reg   <= phase_next;
      bit_cnt_reg <= bit_cnt_next;
      rw_reg      <= rw_next;
      shift_reg   <= shift_next;
      tx_reg      <= tx_next;
      idx_reg     <= idx_next;
      cnt_reg     <= cnt_next;
      sda_oe_reg  <= sda_oe_next;
    end
  end

  // register file, defaults restored while power is reported down
  // RL24: power down restores defaults
  // RL23: masked writes keep reserved zero
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      r0_reg  <= R0_RST;
      r1_reg  <= R1_RST;
      r2_reg  <= R2_RST;
      r3_reg  <= R3_RST;
      r20_reg <= R20_RST;
      r21_reg <= R21_RST;
      r22_reg <= R22_RST;
    end else if (pd_s) begin
      r0_reg  <= R0_RST;
      r1_reg  <= R1_RST;
      r2_reg  <= R2_RST;
      r3_reg  <= R3_RST;
      r20_reg <= R20_RST;
      r21_reg <= R21_RST;
      r22_reg <= R22_RST;
    end else if (wr_en) begin
      // RL4: divider enables follow their pll
      if (idx_reg == REG_PLL_DIV_EN)  r0_reg  <= cgr_fix_pll(shift_reg);
      if (idx_reg == REG_SPREAD_CTL)  r1_reg  <= shift_reg & R1_MASK;
      if (idx_reg == REG_OUT_BUF_EN)  r2_reg  <= shift_reg & R2_MASK;
      if (idx_reg == REG_OUT_MISC)    r3_reg  <= shift_reg & R3_MASK;
      // RL17: high spread word storage
      if (idx_reg == REG_SPREAD_HIGH) r20_reg <= shift_reg & R20_MASK;
      // RL18: divider extension bits kept
      if (idx_reg == REG_CPU_DIV_EXT) r21_reg <= shift_reg & R21_MASK;
      if (idx_reg == REG_PNL_DIV_EXT) r22_reg <= shift_reg & R22_MASK;
    end
  end

  // applied copies move only with the bus idle, so a block write lands
  // as one step instead of glitching enables byte by byte
  // RL24: enables change only when idle
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      a0_reg <= R0_RST;
      a1_reg <= R1_RST;
      a2_reg <= R2_RST;
      a3_reg <= R3_RST;
    end else if (state_reg == ST_IDLE) begin
      a0_reg <= r0_reg;
      a1_reg <= r1_reg;
      a2_reg <= r2_reg;
      a3_reg <= r3_reg;
    end
  end

  // test strap caught once, on the third clock after release once synchronised
  // RL20: latch strap, only reset clears
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      strap_cnt_reg <= 2'h0;
      test_mode_reg <= 1'b0;
    end else if (strap_cnt_reg != 2'h3) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
      if (strap_cnt_reg == 2'h2) test_mode_reg <= tsel_s;
    end
  end

  // per-output enables; halt acts at once, not waiting for idle
  wire [2:0] cpu_buf  = {a2_reg[5], a2_reg[6], a2_reg[7]};
  wire [2:0] cpu_stop = {a3_reg[B3_CPU0_STOP-2], a3_reg[B3_CPU0_STOP-1],
                         a3_reg[B3_CPU0_STOP]};
  wire [2:0] sel_raw  = a1_reg[B1_SEL_LSB +: 3];

  // output flops
  // RL1: pll and divider enables out
  always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      O_SMB_SDA_OUT             <= 1'b0;
      O_SMB_SDA_OE              <= 1'b0;
      O_HOST_PLL_EN             <= 1'b0;
      O_PIXEL_PLL_EN            <= 1'b0;
      O_PANEL_PLL_EN            <= 1'b0;
      O_CPU_DIV_EN              <= 1'b0;
      O_PERIPH_DIV_EN           <= 1'b0;
      O_PANEL_DIV_EN            <= 1'b0;
      O_PIXEL_DIV_EN            <= 1'b0;
      O_HOST_SPREAD_EN          <= 1'b0;
      O_PANEL_SPREAD_EN         <= 1'b0;
      O_PANEL_SPREAD_SELECT     <= 3'h0;
      O_PANEL_SPREAD_CENTRE     <= 1'b0;
      O_CPU_OUT_EN              <= 3'h0;
      O_PERIPH_OUT_EN           <= 3'h0;
      O_PIXEL_OUT_EN            <= 1'b0;
      O_PANEL_OUT_EN            <= 1'b0;
      O_REF_OUT_EN              <= 1'b0;
      O_REF_EDGE_RATE           <= 2'h0;
      O_PANEL_SPREAD_WORD_HIGH  <= 8'h00;
      O_CPU_FEEDBACK_DIV_HIGH   <= 2'h0;
      O_PANEL_FEEDBACK_DIV_HIGH <= 2'h0;
      O_TEST_MODE               <= 1'b0;
      O_TEST_HIZ                <= 1'b0;
      O_TEST_REF_DIV            <= 1'b0;
    end else begin
      O_SMB_SDA_OUT             <= 1'b0; // open drain: only ever pulls low
      O_SMB_SDA_OE              <= sda_oe_reg;
      O_HOST_PLL_EN             <= a0_reg[B0_HOST_PLL];
      // RL2: pixel pll enable
      O_PIXEL_PLL_EN            <= a0_reg[B0_PIXEL_PLL];
      // RL3: panel pll enable
      O_PANEL_PLL_EN            <= a0_reg[B0_PANEL_PLL];
      O_CPU_DIV_EN              <= a0_reg[B0_CPU_DIV];
      O_PERIPH_DIV_EN           <= a0_reg[B0_PERIPH_DIV];
      O_PANEL_DIV_EN            <= a0_reg[B0_PANEL_DIV];
      O_PIXEL_DIV_EN            <= a0_reg[B0_PIXEL_DIV];
      // RL8: host spread fixed down spread
      O_HOST_SPREAD_EN          <= a1_reg[B1_HOST_SS];
      // RL9: panel spread enable
      O_PANEL_SPREAD_EN         <= a1_reg[B1_PANEL_SS];
      // RL10: select gated by spread enable
      O_PANEL_SPREAD_SELECT     <= a1_reg[B1_PANEL_SS] ? sel_raw : 3'h0;
      // RL11: codes from four up are centre
      O_PANEL_SPREAD_CENTRE     <= a1_reg[B1_PANEL_SS] && (sel_raw >= SPR_CENTRE_0P25);
      // RL16: stoppable outputs follow halt
      O_CPU_OUT_EN              <= cpu_buf & ~(cpu_stop & {3{halt_on}});
      // RL12: peripheral buffer enables
      O_PERIPH_OUT_EN           <= {a2_reg[2], a2_reg[3], a2_reg[4]};
      // RL13: pixel and panel buffers
      O_PIXEL_OUT_EN            <= a2_reg[B2_PIXEL_BUF];
      O_PANEL_OUT_EN            <= a2_reg[B2_PANEL_BUF];
      // RL14: reference buffer enable
      O_REF_OUT_EN              <= a3_reg[B3_REF_EN];
      // RL15: reference edge rate field
      O_REF_EDGE_RATE           <= a3_reg[B3_EDGE_LSB +: 2];
      O_PANEL_SPREAD_WORD_HIGH  <= r20_reg;
      O_CPU_FEEDBACK_DIV_HIGH   <= r21_reg[7:6];
      // RL19: panel divider extension out
      O_PANEL_FEEDBACK_DIV_HIGH <= r22_reg[7:6];
      O_TEST_MODE               <= test_mode_reg;
      // RL21: live test output choice
      O_TEST_HIZ                <= test_mode_reg && !tout_s;
      O_TEST_REF_DIV            <= test_mode_reg && tout_s;
    end
  end

  default clocking cb_main @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence s_addr_byte;
    byte_done && (phase_reg == PH_ADDR) && !start_det && !stop_det && !pd_s;
  endsequence
  sequence s_data_write(logic [7:0] idx);
    wr_en && (idx_reg == idx);
  endsequence

  a_addr_accept: assert property (s_addr_byte ##0 addr_hit |=> // RL22
      (state_reg == ST_ACK) && sda_oe_reg ##1 O_SMB_SDA_OE) else $error("address not acked");
  a_addr_reject: assert property (s_addr_byte ##0 !addr_hit |=> // RL22
      (state_reg == ST_IDLE) && !sda_oe_reg) else $error("foreign address acked");
  a_host_div_cut: assert property (!r0_reg[B0_HOST_PLL] |-> // RL4
      !r0_reg[B0_CPU_DIV] && !r0_reg[B0_PERIPH_DIV]) else $error("host dividers live");
  a_panel_div_cut: assert property (!r0_reg[B0_PANEL_PLL] |-> // RL6
      !r0_reg[B0_PANEL_DIV]) else $error("panel divider live");
  a_pixel_div_cut: assert property (!r0_reg[B0_PIXEL_PLL] |-> // RL7
      !r0_reg[B0_PIXEL_DIV]) else $error("pixel divider live");
  a_reserved_zero: assert property (((r0_reg & ~R0_MASK) | (r1_reg & ~R1_MASK) | // RL23
      (r3_reg & ~R3_MASK) | (r21_reg & ~R21_MASK) | (r22_reg & ~R22_MASK)) == 8'h00)
      else $error("reserved bit set");
  a_buf_write: assert property (s_data_write(REG_OUT_BUF_EN) |=> // RL12
      r2_reg == $past(shift_reg)) else $error("buffer write lost");
  a_pd_defaults: assert property (pd_s |=> (r0_reg == R0_RST) && (r1_reg == R1_RST) // RL24
      && (r3_reg == R3_RST) && (state_reg == ST_IDLE)) else $error("power down no reset");
  a_apply_hold: assert property ((state_reg != ST_IDLE) |=> $stable(a0_reg) // RL24
      && $stable(a2_reg)) else $error("enable moved mid transfer");
  a_halt_stop: assert property (halt_on && a3_reg[B3_CPU0_STOP] |=> // RL16
      !O_CPU_OUT_EN[0]) else $error("stoppable cpu output running");
  a_spread_gate: assert property (!a1_reg[B1_PANEL_SS] |=> // RL10
      (O_PANEL_SPREAD_SELECT == 3'h0) && !O_PANEL_SPREAD_CENTRE) else $error("select leaks");
  a_test_sticky: assert property ((strap_cnt_reg == 2'h3) |=> // RL20
      $stable(test_mode_reg)) else $error("test mode changed");
  a_test_hiz: assert property (test_mode_reg && !tout_s |=> // RL21
      O_TEST_HIZ && !O_TEST_REF_DIV) else $error("test hiz missing");

endmodule : cgr_regs

// ---- dv/cgr_host_model.sv ----
// cgr_host_model: behavioural two-wire bus host for the register bank bench.
// assumes SDA is open drain with a pull-up and i_clk is the system clock.
`timescale 1ns/1ps
module cgr_host_model (
  input  wire logic i_clk,
  input  wire logic i_sda_oe,
  output logic      o_scl,
  output wire logic o_sda
);
  logic drv_low;

  assign o_sda = ~(drv_low | i_sda_oe);

  initial begin
    o_scl   = 1'b1;
    drv_low = 1'b0;
  end

  // four clocks a quarter bit, well above the device sync minimum
  task automatic wq();
    repeat (4) @(negedge i_clk);
  endtask : wq

  task automatic start();
    drv_low = 1'b0;
    wq();
    o_scl = 1'b1;
    wq();
    drv_low = 1'b1;
    wq();
    o_scl = 1'b0;
    wq();
  endtask : start

  task automatic stop();
    drv_low = 1'b1;
    wq();
    o_scl = 1'b1;
    wq();
    drv_low = 1'b0;
    wq();
  endtask : stop

  // one bit; data held across the whole high phase, sampled mid-high
  task automatic bitx(input logic b, output logic s);
    drv_low = ~b;
    wq();
    o_scl = 1'b1;
    wq();
    s = o_sda;
    wq();
    o_scl = 1'b0;
    wq();
  endtask : bitx

  task automatic xfer(input logic [7:0] d, input logic ack_in,
                      output logic [7:0] q, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(d[i], q[i]);
    end
    bitx(ack_in, ack);
  endtask : xfer
endmodule : cgr_host_model

// ---- dv/test_cgr_regs.sv ----
// test_cgr_regs: self-checking bench for the clock generator register bank.
// assumes cgr_host_model drives the bus; inputs change on falling edges.
`timescale 1ns/1ps
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin miscompares++; \
  $display("wrong value %s expected %h seen %h", n, e, a); end end
module test_cgr_regs import cgr_pkg::*; ;
  logic        clk, rst, pg, halt_n, tsel, tosel;
  wire         scl, sda, sda_oe, sda_o;
  wire  [35:0] ov;
  wire  [2:0]  tv;
  logic [7:0]  m [256];
  logic [7:0]  cnt;
  int          miscompares, num_checks;

  cgr_regs i_cgr_regs (
    .I_CLK(clk), .I_SYS_RST(rst), .I_SMB_SCL(scl), .I_SMB_SDA(sda),
    .I_POWER_GOOD_POWERDOWN(pg), .I_CPU_CLOCK_HALT_N(halt_n), .I_TEST_SEL(tsel),
    .I_TEST_OUTPUT_SEL(tosel), .O_SMB_SDA_OUT(sda_o), .O_SMB_SDA_OE(sda_oe),
    .O_HOST_PLL_EN(ov[35]), .O_PIXEL_PLL_EN(ov[34]), .O_PANEL_PLL_EN(ov[33]),
    .O_CPU_DIV_EN(ov[32]), .O_PERIPH_DIV_EN(ov[31]), .O_PANEL_DIV_EN(ov[30]),
    .O_PIXEL_DIV_EN(ov[29]), .O_HOST_SPREAD_EN(ov[28]), .O_PANEL_SPREAD_EN(ov[27]),
    .O_PANEL_SPREAD_SELECT(ov[26:24]), .O_PANEL_SPREAD_CENTRE(ov[23]),
    .O_CPU_OUT_EN(ov[22:20]), .O_PERIPH_OUT_EN(ov[19:17]), .O_PIXEL_OUT_EN(ov[16]),
    .O_PANEL_OUT_EN(ov[15]), .O_REF_OUT_EN(ov[14]), .O_REF_EDGE_RATE(ov[13:12]),
    .O_PANEL_SPREAD_WORD_HIGH(ov[11:4]), .O_CPU_FEEDBACK_DIV_HIGH(ov[3:2]),
    .O_PANEL_FEEDBACK_DIV_HIGH(ov[1:0]), .O_TEST_MODE(tv[2]), .O_TEST_HIZ(tv[1]),
    .O_TEST_REF_DIV(tv[0])
  );
  cgr_host_model i_cgr_host_model (.i_clk(clk), .i_sda_oe(sda_oe), .o_scl(scl), .o_sda(sda));

  initial clk = 1'b0;
  always #20 clk = ~clk;

  function automatic logic [35:0] expo();
    logic [2:0] stp;
    logic [2:0] sel;
    stp = {m[3][0], m[3][1], m[3][2]} & {3{~halt_n}};
    sel = m[1][6] ? m[1][5:3] : 3'h0;
    expo = {m[0][7:5], m[0][3:0], m[1][7:6], sel, m[1][6] & sel[2],
            {m[2][5], m[2][6], m[2][7]} & ~stp, m[2][2], m[2][3], m[2][4], m[2][1:0],
            m[3][5:3], m[20], m[21][7:6], m[22][7:6]};
  endfunction : expo

  function automatic logic [7:0] msk(input logic [7:0] i);
    case (i)
      REG_PLL_DIV_EN:  msk = R0_MASK;
      REG_SPREAD_CTL:  msk = R1_MASK;
      REG_OUT_BUF_EN:  msk = R2_MASK;
      REG_OUT_MISC:    msk = R3_MASK;
      REG_SPREAD_HIGH: msk = R20_MASK;
      REG_CPU_DIV_EXT: msk = R21_MASK;
      REG_PNL_DIV_EXT: msk = R22_MASK;
      default:         msk = 8'h00;
    endcase
  endfunction : msk

  task automatic dflt();
    foreach (m[k]) m[k] = 8'h00;
    m[0] = R0_RST;
    m[1] = R1_RST;
    m[2] = R2_RST;
    m[3] = R3_RST;
  endtask : dflt

  task automatic snd(input logic [7:0] d);
    logic [7:0] q;
    logic       a;
    i_cgr_host_model.xfer(d, 1'b1, q, a);
    `CHK("write ack", 1'b0, a)
  endtask : snd

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    i_cgr_host_model.start();
    snd(SMB_ADDR_WR);
    snd(i);
    snd(8'h01);
    snd(d);
    i_cgr_host_model.stop();
    d = d & msk(i);
    if (i == REG_PLL_DIV_EN) d = d & ~{4'h0, ~d[7], ~d[7], ~d[5], ~d[6]};
    m[i] = d;
    cnt = 8'h01;
    repeat (6) @(negedge clk);
    `CHK("outputs", expo(), ov)
  endtask : wr

  task automatic rd(input logic [7:0] i);
    logic [7:0] q;
    logic       a;
    i_cgr_host_model.start();
    snd(SMB_ADDR_WR);
    snd(i);
    i_cgr_host_model.start();
    snd(SMB_ADDR_RD);
    i_cgr_host_model.xfer(8'hFF, 1'b0, q, a);
    `CHK("count byte", cnt, q)
    i_cgr_host_model.xfer(8'hFF, 1'b1, q, a);
    `CHK("read data", m[i], q)
    i_cgr_host_model.stop();
  endtask : rd

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : tally_and_finish

  // watchdog, about two and a half times the expected run
  initial begin
    repeat (60000) @(posedge clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    logic [7:0] tbl [8];
    logic [7:0] i, d;
    logic       a;
    int unsigned s;
    {rst, pg, halt_n, tsel, tosel} = 5'b10100;
    s = $urandom(32'hCA3A);
    tbl = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h14, 8'h15, 8'h16, 8'h09};
    dflt();
    cnt = 8'h07;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("reset outputs", expo(), ov)
    `CHK("normal mode", 3'b000, tv)
    `CHK("sda drive level", 1'b0, sda_o)
    rd(REG_PLL_DIV_EN);
    wr(REG_PLL_DIV_EN, 8'h5F);
    wr(REG_PLL_DIV_EN, 8'h9F);
    for (int c = 0; c < 8; c++) wr(REG_SPREAD_CTL, {2'b11, c[2:0], 3'h7});
    wr(REG_SPREAD_CTL, 8'hBC);
    repeat (10) begin
      i = tbl[$urandom % 8];
      d = 8'($urandom);
      wr(i, d);
      rd(i);
    end
    // two data bytes in one transfer: index must step by one
    i_cgr_host_model.start();
    snd(SMB_ADDR_WR);
    snd(REG_SPREAD_HIGH);
    snd(8'h02);
    snd(8'hA5);
    snd(8'hFF);
    i_cgr_host_model.stop();
    m[REG_SPREAD_HIGH] = 8'hA5;
    m[REG_CPU_DIV_EXT] = 8'hFF & R21_MASK;
    repeat (6) @(negedge clk);
    `CHK("block write", expo(), ov)
    wr(REG_OUT_BUF_EN, 8'hFF);
    wr(REG_OUT_MISC, 8'h35);
    halt_n = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("halted outputs", expo(), ov)
    halt_n = 1'b1;
    i_cgr_host_model.start();
    i_cgr_host_model.xfer(8'hA0, 1'b1, d, a);
    `CHK("foreign ack", 1'b1, a)
    i_cgr_host_model.stop();
    pg = 1'b1;
    repeat (6) @(negedge clk);
    dflt();
    `CHK("powerdown outputs", expo(), ov)
    pg = 1'b0;
    tsel = 1'b1;
    rst = 1'b1;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    repeat (6) @(negedge clk);
    `CHK("test hiz", 3'b110, tv)
    tosel = 1'b1;
    repeat (6) @(negedge clk);
    `CHK("test ref", 3'b101, tv)
    tally_and_finish();
  end
endmodule : test_cgr_regs
